// [region_decoder_defs.svh]
// Constants of the address region decoder: register offsets, reset values and region limits.
// Assumes a 32-bit address space and an AHB-Lite register window decoded on HADDR[7:0].
`ifndef REGION_DECODER_DEFS_SVH
`define REGION_DECODER_DEFS_SVH

`define ADDR_W 32
`define DATA_W 32
`define REG_OFS_W 8
`define MB_LSB 20
`define MB_W 12
`define GIG_LSB 30
`define GIG_W 2
`define ERR_CNT_W 16
`define SLV_IDX_W 4

// Register offsets.
`define REG_WIN_START 8'h00
`define REG_WIN_END 8'h04
`define REG_REMAP 8'h08
`define REG_COH_SEL 8'h0C
`define REG_STATUS 8'h10
`define REG_ERR_CNT 8'h14

// Reset values, in megabyte units for the window limits.
`define WIN_START_RST 12'h001
`define WIN_END_RST 12'hC00
`define REMAP_RST 1'b0
`define COH_SEL_RST 2'h0

// Field positions.
`define REMAP_BIT 0
`define STAT_PTGT_LSB 0
`define STAT_ITGT_LSB 4
`define STAT_PERR_BIT 8
`define STAT_IERR_BIT 9
`define STAT_PSLV_LSB 12
`define STAT_ISLV_LSB 16

// Region limits.
`define BOOT_START_MB 12'h001
`define BOOT_TOP 32'h0010_0000
`define BOOT_LEGAL_TOP 32'h0001_0000
`define FABRIC_BASE 32'hC000_0000
`define PERIPHERAL_REGION_BASE 32'hFC00_0000
`define IC_SDRAM_TOP 32'h8000_0000
`define IC_LOW_RAM_TOP 32'h0001_0000
`define COH_BASE 32'h8000_0000
`define COH_TOP 32'hC000_0000

// Peripheral slave table, entry 0 in the low word.
`define SLV_NUM 14
`define IDX_LIGHT 4'd2
`define IDX_SDRAM_CTRL 4'd8
`define IDX_BOOT_ROM 4'd10
`define IDX_SNOOP 4'd11
`define IDX_CACHE_CTRL 4'd12
`define IDX_ONCHIP_RAM 4'd13
`define SLV_BASES {32'hFFFF_0000, 32'hFFFE_F000, 32'hFFFE_C000, 32'hFFFD_0000, \
   32'hFFD0_8000, 32'hFFC2_0000, 32'hFF80_0000, 32'hFF70_0000, 32'hFF60_0000, \
   32'hFF50_0000, 32'hFF40_0000, 32'hFF20_0000, 32'hFF00_0000, 32'hFC00_0000}
`define SLV_SIZES {32'h0001_0000, 32'h0000_1000, 32'h0000_2000, 32'h0001_0000, \
   32'h0000_4000, 32'h0002_0000, 32'h0010_0000, 32'h0000_2000, 32'h0010_0000, \
   32'h0010_0000, 32'h0010_0000, 32'h0020_0000, 32'h0020_0000, 32'h0300_0000}

`endif

// [region_decoder_pkg.sv]
// Types shared by the address region decoder modules.
// Assumes the constants of region_decoder_defs.svh.
package region_decoder_pkg;

   typedef enum logic [3:0] {
      TGT_ERROR = 4'h0,
      TGT_SDRAM = 4'h1,
      TGT_INTERCONNECT = 4'h2,
      TGT_BOOT_ROM = 4'h3,
      TGT_ONCHIP_RAM = 4'h4,
      TGT_FABRIC_BRIDGE = 4'h5,
      TGT_LIGHT_BRIDGE = 4'h6,
      TGT_PERIPHERAL_REGION_SLAVE = 4'h7,
      TGT_SNOOP_CTRL = 4'h8,
      TGT_CACHE_CTRL_REGS = 4'h9,
      TGT_SDRAM_CTRL_REGS = 4'hA,
      TGT_COHERENT = 4'hB
   } target_t;

endpackage

// [sdram_window_compare.sv]
// Megabyte-granular comparison of an address against a start and an exclusive end limit.
// Assumes the limits are held in megabyte units by the caller.
`include "region_decoder_defs.svh"

module sdram_window_compare #(
   parameter int ADDR_W = `ADDR_W,
   parameter int MB_W = `MB_W
) (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [MB_W-1:0] start_mb,
   input wire logic [MB_W-1:0] end_mb,
   output logic in_window
);

   logic [MB_W-1:0] addr_mb;

   assign addr_mb = addr[ADDR_W-1:`MB_LSB];
   assign in_window = (addr_mb >= start_mb) && (addr_mb < end_mb);

endmodule // sdram_window_compare

// [peripheral_region_slave_match.sv]
// Range match of an address against every entry of the peripheral slave table.
// Assumes bases and sizes are packed with entry 0 in the low word.
`include "region_decoder_defs.svh"

module peripheral_region_slave_match #(
   parameter int ADDR_W = `ADDR_W,
   parameter int NUM = `SLV_NUM,
   parameter logic [NUM*ADDR_W-1:0] BASES = `SLV_BASES,
   parameter logic [NUM*ADDR_W-1:0] SIZES = `SLV_SIZES
) (
   input wire logic [ADDR_W-1:0] addr,
   output logic [NUM-1:0] hit
);

   genvar i;
   generate
      for (i = 0; i < NUM; i++) begin : g_entry
         logic [ADDR_W-1:0] ofs;
         assign ofs = addr - BASES[i*ADDR_W +: ADDR_W];
         assign hit[i] = (addr >= BASES[i*ADDR_W +: ADDR_W]) && (ofs < SIZES[i*ADDR_W +: ADDR_W]);
      end
   endgenerate

endmodule // peripheral_region_slave_match

// [region_decoder.sv]
// Address region decoder for the processor map and the interconnect master map.
// Assumes one request per master per cycle and an AHB-Lite bus for its configuration.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`include "region_decoder_defs.svh"

module region_decoder
   import region_decoder_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W,
   parameter int DATA_W = `DATA_W,
   parameter int ERR_CNT_W = `ERR_CNT_W
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic HSEL,
   input wire logic [ADDR_W-1:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [DATA_W-1:0] HWDATA,
   input wire logic HREADY,
   output logic [DATA_W-1:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic PROC_REQ_VALID,
   input wire logic [ADDR_W-1:0] PROC_REQ_ADDR,
   output logic PROC_ROUTE_VALID,
   output region_decoder_pkg::target_t PROC_ROUTE_TARGET,
   output logic [ADDR_W-1:0] PROC_ROUTE_ADDR,
   output logic [`SLV_IDX_W-1:0] PROC_ROUTE_SLAVE,
   output logic PROC_ROUTE_SDRAM_SIDE,
   output logic PROC_ROUTE_ERR,
   input wire logic IC_REQ_VALID,
   input wire logic [ADDR_W-1:0] IC_REQ_ADDR,
   output logic IC_ROUTE_VALID,
   output region_decoder_pkg::target_t IC_ROUTE_TARGET,
   output logic [ADDR_W-1:0] IC_ROUTE_ADDR,
   output logic [`SLV_IDX_W-1:0] IC_ROUTE_SLAVE,
   output logic IC_ROUTE_ERR
);

   import region_decoder_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [`MB_W-1:0] win_start_ff;
      logic [`MB_W-1:0] win_end_ff;
      logic remap_ff;
      logic [`GIG_W-1:0] coh_sel_ff;
      logic wr_pend_ff;
      logic [`REG_OFS_W-1:0] wr_ofs_ff;
      logic [DATA_W-1:0] rdata_ff;
      logic p_valid_ff;
      target_t p_tgt_ff;
      logic [ADDR_W-1:0] p_addr_ff;
      logic [`SLV_IDX_W-1:0] p_slv_ff;
      logic p_sdram_ff;
      logic i_valid_ff;
      target_t i_tgt_ff;
      logic [ADDR_W-1:0] i_addr_ff;
      logic [`SLV_IDX_W-1:0] i_slv_ff;
      logic [ERR_CNT_W-1:0] err_cnt_ff;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   logic p_in_win;
   logic [`SLV_NUM-1:0] p_hit;
   logic [`SLV_NUM-1:0] i_hit;
   logic ahb_take;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic [`SLV_IDX_W-1:0] first_hit(input logic [`SLV_NUM-1:0] hit);
      logic [`SLV_IDX_W-1:0] idx;
      idx = '0;
      for (int k = `SLV_NUM - 1; k >= 0; k--) begin
         if (hit[k]) begin
            idx = k[`SLV_IDX_W-1:0];
         end
      end
      return idx;
   endfunction

   function automatic target_t slave_kind(input logic [`SLV_IDX_W-1:0] idx);
      target_t kind;
      kind = TGT_PERIPHERAL_REGION_SLAVE;
      if (idx == `IDX_LIGHT) begin
         kind = TGT_LIGHT_BRIDGE;
      end else if (idx == `IDX_SDRAM_CTRL) begin
         kind = TGT_SDRAM_CTRL_REGS;
      end else if (idx == `IDX_BOOT_ROM) begin
         kind = TGT_BOOT_ROM;
      end else if (idx == `IDX_ONCHIP_RAM) begin
         kind = TGT_ONCHIP_RAM;
      end else if (idx == `IDX_SNOOP) begin
         kind = TGT_SNOOP_CTRL;
      end else if (idx == `IDX_CACHE_CTRL) begin
         kind = TGT_CACHE_CTRL_REGS;
      end
      return kind;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Range comparators.

   sdram_window_compare #(
      .ADDR_W(ADDR_W),
      .MB_W(`MB_W)
   ) u_win (
      .addr(PROC_REQ_ADDR),
      .start_mb(state_ff.win_start_ff),
      .end_mb(state_ff.win_end_ff),
      .in_window(p_in_win)
   );

   peripheral_region_slave_match #(
      .ADDR_W(ADDR_W),
      .NUM(`SLV_NUM)
   ) u_p_match (
      .addr(PROC_REQ_ADDR),
      .hit(p_hit)
   );

   peripheral_region_slave_match #(
      .ADDR_W(ADDR_W),
      .NUM(`SLV_NUM)
   ) u_i_match (
      .addr(IC_REQ_ADDR),
      .hit(i_hit)
   );

   assign ahb_take = HSEL && HREADY && HTRANS[1];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      logic [`SLV_IDX_W-1:0] p_idx;
      logic [`SLV_IDX_W-1:0] i_idx;
      logic p_err;
      logic i_err;
      p_idx = first_hit(p_hit);
      i_idx = first_hit(i_hit);
      p_err = 1'b0;
      i_err = 1'b0;
      nxt_state = state_ff;

      // Processor map decode.
      nxt_state.p_valid_ff = PROC_REQ_VALID;
      nxt_state.p_tgt_ff = TGT_ERROR;
      nxt_state.p_slv_ff = '0;
      nxt_state.p_addr_ff = PROC_REQ_ADDR;
      if (p_in_win) begin
         nxt_state.p_tgt_ff = TGT_SDRAM;
      // boot region needs 1 MB start.
      end else if (PROC_REQ_ADDR < `BOOT_TOP && state_ff.win_start_ff == `BOOT_START_MB) begin
         if (PROC_REQ_ADDR < `BOOT_LEGAL_TOP) begin
            nxt_state.p_tgt_ff = state_ff.remap_ff ? TGT_ONCHIP_RAM : TGT_BOOT_ROM;
         end
      end else if (PROC_REQ_ADDR >= `FABRIC_BASE && PROC_REQ_ADDR < `PERIPHERAL_REGION_BASE) begin
         nxt_state.p_tgt_ff = TGT_FABRIC_BRIDGE;
      end else if (PROC_REQ_ADDR >= `PERIPHERAL_REGION_BASE && (|p_hit)) begin
         nxt_state.p_tgt_ff = slave_kind(p_idx);
         nxt_state.p_slv_ff = p_idx;
      end
      nxt_state.p_sdram_ff = p_in_win;
      p_err = PROC_REQ_VALID && (nxt_state.p_tgt_ff == TGT_ERROR);

      // Interconnect map decode.
      // separate interconnect map.
      nxt_state.i_valid_ff = IC_REQ_VALID;
      nxt_state.i_tgt_ff = TGT_ERROR;
      nxt_state.i_slv_ff = '0;
      nxt_state.i_addr_ff = IC_REQ_ADDR;
      if (IC_REQ_ADDR < `IC_SDRAM_TOP) begin
         nxt_state.i_tgt_ff = TGT_SDRAM;
         if (state_ff.remap_ff && IC_REQ_ADDR < `IC_LOW_RAM_TOP) begin
            nxt_state.i_tgt_ff = TGT_ONCHIP_RAM;
         end
      end else if (IC_REQ_ADDR >= `COH_BASE && IC_REQ_ADDR < `COH_TOP) begin
         nxt_state.i_tgt_ff = TGT_COHERENT;
         nxt_state.i_addr_ff = {state_ff.coh_sel_ff, IC_REQ_ADDR[`GIG_LSB-1:0]};
      end else if (IC_REQ_ADDR < `PERIPHERAL_REGION_BASE) begin
         nxt_state.i_tgt_ff = TGT_FABRIC_BRIDGE;
      end else if (|i_hit) begin
         if (i_idx != `IDX_BOOT_ROM && i_idx != `IDX_SNOOP && i_idx != `IDX_CACHE_CTRL) begin
            nxt_state.i_tgt_ff = slave_kind(i_idx);
            nxt_state.i_slv_ff = i_idx;
         end
      end
      i_err = IC_REQ_VALID && (nxt_state.i_tgt_ff == TGT_ERROR);

      // The counter saturates so a flood of bad addresses never wraps to a small value.
      if ((p_err || i_err) && (state_ff.err_cnt_ff != '1)) begin
         nxt_state.err_cnt_ff = state_ff.err_cnt_ff + ERR_CNT_W'(1);
      end

      // Register writes commit in the data phase.
      nxt_state.wr_pend_ff = ahb_take && HWRITE;
      nxt_state.wr_ofs_ff = HADDR[`REG_OFS_W-1:0];
      if (state_ff.wr_pend_ff) begin
         if (state_ff.wr_ofs_ff == `REG_WIN_START) begin
            nxt_state.win_start_ff = HWDATA[`MB_W-1:0];
         end else if (state_ff.wr_ofs_ff == `REG_WIN_END) begin
            nxt_state.win_end_ff = HWDATA[`MB_W-1:0];
         end else if (state_ff.wr_ofs_ff == `REG_REMAP) begin
            nxt_state.remap_ff = HWDATA[`REMAP_BIT];
         end else if (state_ff.wr_ofs_ff == `REG_COH_SEL) begin
            nxt_state.coh_sel_ff = HWDATA[`GIG_W-1:0];
         end else if (state_ff.wr_ofs_ff == `REG_ERR_CNT) begin
            nxt_state.err_cnt_ff = '0;
         end
      end

      // Reads sample the values after any write in flight, so back to back works.
      if (ahb_take && !HWRITE) begin
         nxt_state.rdata_ff = '0;
         if (HADDR[`REG_OFS_W-1:0] == `REG_WIN_START) begin
            nxt_state.rdata_ff[`MB_W-1:0] = nxt_state.win_start_ff;
         end else if (HADDR[`REG_OFS_W-1:0] == `REG_WIN_END) begin
            nxt_state.rdata_ff[`MB_W-1:0] = nxt_state.win_end_ff;
         end else if (HADDR[`REG_OFS_W-1:0] == `REG_REMAP) begin
            nxt_state.rdata_ff[`REMAP_BIT] = nxt_state.remap_ff;
         end else if (HADDR[`REG_OFS_W-1:0] == `REG_COH_SEL) begin
            nxt_state.rdata_ff[`GIG_W-1:0] = nxt_state.coh_sel_ff;
         end else if (HADDR[`REG_OFS_W-1:0] == `REG_STATUS) begin
            nxt_state.rdata_ff[`STAT_PTGT_LSB +: 4] = state_ff.p_tgt_ff;
            nxt_state.rdata_ff[`STAT_ITGT_LSB +: 4] = state_ff.i_tgt_ff;
            nxt_state.rdata_ff[`STAT_PERR_BIT] = state_ff.p_valid_ff && state_ff.p_tgt_ff == TGT_ERROR;
            nxt_state.rdata_ff[`STAT_IERR_BIT] = state_ff.i_valid_ff && state_ff.i_tgt_ff == TGT_ERROR;
            nxt_state.rdata_ff[`STAT_PSLV_LSB +: `SLV_IDX_W] = state_ff.p_slv_ff;
            nxt_state.rdata_ff[`STAT_ISLV_LSB +: `SLV_IDX_W] = state_ff.i_slv_ff;
         end else if (HADDR[`REG_OFS_W-1:0] == `REG_ERR_CNT) begin
            nxt_state.rdata_ff[ERR_CNT_W-1:0] = nxt_state.err_cnt_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state_ff <= '0;
         state_ff.win_start_ff <= `WIN_START_RST;
         state_ff.win_end_ff <= `WIN_END_RST;
         state_ff.remap_ff <= `REMAP_RST;
         state_ff.coh_sel_ff <= `COH_SEL_RST;
         state_ff.p_tgt_ff <= TGT_ERROR;
         state_ff.i_tgt_ff <= TGT_ERROR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Zero wait states; every register access is answered OKAY.
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = state_ff.rdata_ff;

   assign PROC_ROUTE_VALID = state_ff.p_valid_ff;
   assign PROC_ROUTE_TARGET = state_ff.p_tgt_ff;
   assign PROC_ROUTE_ADDR = state_ff.p_addr_ff;
   assign PROC_ROUTE_SLAVE = state_ff.p_slv_ff;
   assign PROC_ROUTE_SDRAM_SIDE = state_ff.p_valid_ff && state_ff.p_sdram_ff;
   assign PROC_ROUTE_ERR = state_ff.p_valid_ff && (state_ff.p_tgt_ff == TGT_ERROR);

   assign IC_ROUTE_VALID = state_ff.i_valid_ff;
   assign IC_ROUTE_TARGET = state_ff.i_tgt_ff;
   assign IC_ROUTE_ADDR = state_ff.i_addr_ff;
   assign IC_ROUTE_SLAVE = state_ff.i_slv_ff;
   assign IC_ROUTE_ERR = state_ff.i_valid_ff && (state_ff.i_tgt_ff == TGT_ERROR);

endmodule // region_decoder

// [region_decoder_monitor.sv]
// Concurrent checks on the ports of the address region decoder.
// Assumes one clock, a synchronous active-high reset and the target codes of the package.
module region_decoder_monitor
   import region_decoder_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic PROC_REQ_VALID,
   input wire logic [31:0] PROC_REQ_ADDR,
   input wire logic PROC_ROUTE_VALID,
   input wire region_decoder_pkg::target_t PROC_ROUTE_TARGET,
   input wire logic [31:0] PROC_ROUTE_ADDR,
   input wire logic PROC_ROUTE_SDRAM_SIDE,
   input wire logic PROC_ROUTE_ERR,
   input wire logic IC_REQ_VALID,
   input wire logic [31:0] IC_REQ_ADDR,
   input wire region_decoder_pkg::target_t IC_ROUTE_TARGET,
   input wire logic [31:0] IC_ROUTE_ADDR,
   input wire logic [3:0] IC_ROUTE_SLAVE,
   input wire logic IC_ROUTE_ERR
);
   import region_decoder_pkg::*;

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   ////////////////////////////////////////////////////////////////////////////////////////////
   a_proc_addr_kept: assert property (
      PROC_REQ_VALID |=> PROC_ROUTE_VALID && PROC_ROUTE_ADDR == $past(PROC_REQ_ADDR))
      else $error("Processor route lost its request or address.");
   a_err_flag_tied: assert property (
      PROC_ROUTE_ERR == (PROC_ROUTE_VALID && PROC_ROUTE_TARGET == TGT_ERROR))
      else $error("Processor error flag disagrees with the target.");
   a_side_is_sdram: assert property (
      PROC_ROUTE_SDRAM_SIDE == (PROC_ROUTE_VALID && PROC_ROUTE_TARGET == TGT_SDRAM))
      else $error("Processor side select disagrees with the target.");
   a_ic_fabric_span: assert property (
      IC_REQ_VALID && IC_REQ_ADDR >= 32'hC000_0000 && IC_REQ_ADDR < 32'hFC00_0000
      |=> IC_ROUTE_TARGET == TGT_FABRIC_BRIDGE)
      else $error("Fabric span not sent to the fabric bridge.");
   a_ic_coherent_map: assert property (
      IC_REQ_VALID && IC_REQ_ADDR[31:30] == 2'b10 |=> IC_ROUTE_TARGET == TGT_COHERENT
      && ((IC_ROUTE_ADDR ^ $past(IC_REQ_ADDR)) & 32'h3FFF_FFFF) == 32'h0)
      else $error("Coherent window offset not kept.");
   a_ic_sdram_low: assert property (
      IC_REQ_VALID && !IC_REQ_ADDR[31] && IC_REQ_ADDR[31:16] != 16'h0000
      |=> IC_ROUTE_TARGET == TGT_SDRAM && IC_ROUTE_ADDR == $past(IC_REQ_ADDR))
      else $error("Low interconnect address not sent straight to SDRAM.");
   a_ic_hides_private: assert property (
      IC_REQ_VALID && (IC_REQ_ADDR[31:16] == 16'hFFFD || IC_REQ_ADDR[31:13] == 19'h7FFF6
      || IC_REQ_ADDR[31:12] == 20'hFFFEF) |=> IC_ROUTE_ERR)
      else $error("Interconnect master reached a processor-only slave.");
   a_light_window: assert property (
      IC_REQ_VALID && IC_REQ_ADDR[31:21] == 11'h7F9
      |=> IC_ROUTE_TARGET == TGT_LIGHT_BRIDGE && IC_ROUTE_SLAVE == 4'h2)
      else $error("Light window not sent to the light bridge.");
   a_proc_ram_fixed: assert property (
      PROC_REQ_VALID && PROC_REQ_ADDR[31:16] == 16'hFFFF |=> PROC_ROUTE_TARGET == TGT_ONCHIP_RAM)
      else $error("On-chip RAM alias missing from the processor map.");
   a_proc_cache_regs: assert property (
      PROC_REQ_VALID && PROC_REQ_ADDR[31:12] == 20'hFFFEF
      |=> PROC_ROUTE_TARGET == TGT_CACHE_CTRL_REGS)
      else $error("Cache controller registers not decoded.");
   a_sdram_ctrl_slave: assert property (
      IC_REQ_VALID && IC_REQ_ADDR[31:17] == 15'h7FE1
      |=> IC_ROUTE_TARGET == TGT_SDRAM_CTRL_REGS && IC_ROUTE_SLAVE == 4'h8)
      else $error("SDRAM controller register slave not decoded.");
   a_bus_always_okay: assert property (
      HREADYOUT && !HRESP)
      else $error("Register bus stalled or answered with an error.");
endmodule // region_decoder_monitor

bind region_decoder region_decoder_monitor i_region_decoder_monitor (
   .CORE_CLK, .SYS_RST, .HREADYOUT, .HRESP, .PROC_REQ_VALID, .PROC_REQ_ADDR,
   .PROC_ROUTE_VALID, .PROC_ROUTE_TARGET, .PROC_ROUTE_ADDR, .PROC_ROUTE_SDRAM_SIDE,
   .PROC_ROUTE_ERR, .IC_REQ_VALID, .IC_REQ_ADDR, .IC_ROUTE_TARGET, .IC_ROUTE_ADDR,
   .IC_ROUTE_SLAVE, .IC_ROUTE_ERR
);

// [proc_master_model.sv]
// Model of a processor master that presents one address request per cycle.
// Assumes the bench asks for a request just after a rising edge.
module proc_master_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [31:0] go_addr,
   output logic req_valid,
   output logic [31:0] req_addr
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // An idle address bus shows the inverse of its last value, so stale data never matches.
   always_ff @(posedge clk) begin
      if (rst) begin
         req_valid <= 1'b0;
         req_addr <= 32'h0;
      end else begin
         req_valid <= go;
         req_addr <= go ? ((go_addr[31:20] == 12'h000) ? {16'h0, go_addr[15:0]} : go_addr)
                        : ~req_addr;
      end
   end
endmodule // proc_master_model

// [region_decoder_bench.sv]
// Self-checking bench of the address region decoder, with random and boundary traffic.
// Assumes the register layout and decode order stated for the design.
`include "region_decoder_defs.svh"

module region_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import region_decoder_pkg::*;

   typedef struct packed {target_t tgt; logic [31:0] adr;} note_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, go = 1'b0, ic_valid = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, go_addr = 32'h0, ic_addr = 32'h0;
   logic p_valid, pr_valid, pr_side, pr_err, ir_valid, ir_err;
   logic [31:0] p_addr, pr_addr, ir_addr;
   logic [3:0] pr_slv, ir_slv;
   target_t pr_tgt, ir_tgt;
   logic [11:0] ws = 12'h001, we = 12'hC00;
   logic rm = 1'b0;
   logic [1:0] coh = 2'h0;
   note_t pq[$], iq[$], pn, inn;
   int bad_count = 0, samples_checked = 0;
   logic [31:0] picks [24] = '{32'hFF20_0000, 32'hFF3F_FFFC, 32'hFFC2_0000, 32'hFFC3_FFFC,
      32'hFFFD_0000, 32'hFFFE_C000, 32'hFFFE_F000, 32'hFFFF_0000, 32'hFFE0_0000, 32'hFC00_0000,
      32'hFF10_0000, 32'hC000_0000, 32'hFBFF_FFFC, 32'hBFFF_FFFC, 32'h8000_0000, 32'h7FFF_FFFC,
      32'h0000_FFFC, 32'h0001_0000, 32'h000F_FFFC, 32'h0010_0000, 32'h0FFF_FFFC, 32'h1000_0000,
      32'h100F_FFFC, 32'h1010_0000};

   always #5 clk = ~clk;

   region_decoder i_region_decoder (.CORE_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PROC_REQ_VALID(p_valid),
      .PROC_REQ_ADDR(p_addr), .PROC_ROUTE_VALID(pr_valid), .PROC_ROUTE_TARGET(pr_tgt),
      .PROC_ROUTE_ADDR(pr_addr), .PROC_ROUTE_SLAVE(pr_slv), .PROC_ROUTE_SDRAM_SIDE(pr_side),
      .PROC_ROUTE_ERR(pr_err), .IC_REQ_VALID(ic_valid), .IC_REQ_ADDR(ic_addr),
      .IC_ROUTE_VALID(ir_valid), .IC_ROUTE_TARGET(ir_tgt), .IC_ROUTE_ADDR(ir_addr),
      .IC_ROUTE_SLAVE(ir_slv), .IC_ROUTE_ERR(ir_err));
   proc_master_model i_proc_master_model (.clk(clk), .rst(rst), .go(go), .go_addr(go_addr),
      .req_valid(p_valid), .req_addr(p_addr));

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done;
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // One single-word transfer; zero wait states are expected but not assumed.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      check(nm, rd, e);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic target_t peripheral_region(logic [31:0] a, logic proc);
      if (a[31:21] == 11'h7F9) return TGT_LIGHT_BRIDGE;
      if (a[31:17] == 15'h7FE1) return TGT_SDRAM_CTRL_REGS;
      if (a[31:16] == 16'hFFFD) return proc ? TGT_BOOT_ROM : TGT_ERROR;
      if (a[31:13] == 19'h7FFF6) return proc ? TGT_SNOOP_CTRL : TGT_ERROR;
      if (a[31:12] == 20'hFFFEF) return proc ? TGT_CACHE_CTRL_REGS : TGT_ERROR;
      if (a[31:16] == 16'hFFFF) return TGT_ONCHIP_RAM;
      return (a < 32'hFF20_0000) ? TGT_PERIPHERAL_REGION_SLAVE : TGT_ERROR;
   endfunction

   function automatic target_t p_exp(logic [31:0] a);
      if (a[31:20] >= ws && a[31:20] < we) return TGT_SDRAM;
      if (a[31:20] == 12'h000 && ws == 12'h001) return rm ? TGT_ONCHIP_RAM : TGT_BOOT_ROM;
      if (a >= 32'hFC00_0000) return peripheral_region(a, 1'b1);
      return (a >= 32'hC000_0000) ? TGT_FABRIC_BRIDGE : TGT_ERROR;
   endfunction

   function automatic note_t i_exp(logic [31:0] a);
      note_t n;
      n.adr = a;
      if (!a[31]) n.tgt = (rm && a < 32'h0001_0000) ? TGT_ONCHIP_RAM : TGT_SDRAM;
      else if (a < 32'hC000_0000) n = '{TGT_COHERENT, {coh, a[29:0]}};
      else if (a < 32'hFC00_0000) n.tgt = TGT_FABRIC_BRIDGE;
      else n.tgt = peripheral_region(a, 1'b0);
      return n;
   endfunction

   // Both masters fire at random, half of the time at a boundary or a mapped slave.
   task automatic traffic(input int n);
      logic [31:0] a;
      logic [31:0] b;
      logic vp;
      logic vi;
      repeat (n) begin
         @(posedge clk);
         a = ($urandom % 2) ? picks[$urandom % 24] : $urandom % 32'hFC00_0000;
         b = ($urandom % 2) ? picks[$urandom % 24] : $urandom % 32'hFC00_0000;
         a = (a[31:20] == 12'h000) ? {16'h0, a[15:0]} : a;
         vp = ($urandom % 4) != 0;
         vi = ($urandom % 4) != 0;
         go <= vp;
         go_addr <= a;
         ic_valid <= vi;
         ic_addr <= b;
         if (vp) pq.push_back('{p_exp(a), a});
         if (vi) iq.push_back(i_exp(b));
      end
      @(posedge clk);
      go <= 1'b0;
      ic_valid <= 1'b0;
      repeat (4) @(posedge clk);
      check("proc_left", pq.size(), 0);
      check("ic_left", iq.size(), 0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (!rst && pr_valid === 1'b1) begin
         check("proc_queued", pq.size() != 0, 1'b1);
         pn = pq.pop_front();
         check("proc_target", {28'h0, pr_tgt}, {28'h0, pn.tgt});
         check("proc_addr", pr_addr, pn.adr);
         check("proc_side", pr_side, pn.tgt == TGT_SDRAM);
         check("proc_err", pr_err, pn.tgt == TGT_ERROR);
         check("proc_slave", pr_slv == 4'hD, pn.tgt == TGT_ONCHIP_RAM && pn.adr[31:16] == 16'hFFFF);
      end
      if (!rst && ir_valid === 1'b1) begin
         check("ic_queued", iq.size() != 0, 1'b1);
         inn = iq.pop_front();
         check("ic_target", {28'h0, ir_tgt}, {28'h0, inn.tgt});
         check("ic_addr", ir_addr, inn.adr);
         check("ic_err", ir_err, inn.tgt == TGT_ERROR);
      end
   end

   // The whole run takes well under two thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done();
   end

   initial begin
      rd = $urandom(13393);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("route_idle", pr_valid | ir_valid, 1'b0);
      rdchk(`REG_WIN_START, 32'h001, "win_start");
      rdchk(`REG_WIN_END, 32'hC00, "win_end");
      rdchk(`REG_REMAP, 32'h0, "remap");
      rdchk(8'h40, 32'h0, "unmapped");
      traffic(80);
      bus(1'b1, `REG_REMAP, 32'h1);
      bus(1'b1, `REG_COH_SEL, 32'h2);
      rm = 1'b1;
      coh = 2'h2;
      rdchk(`REG_COH_SEL, 32'h2, "coh_sel");
      traffic(80);
      bus(1'b1, `REG_WIN_START, 32'h0);
      bus(1'b1, `REG_WIN_END, 32'hFC0);
      ws = 12'h000;
      we = 12'hFC0;
      traffic(80);
      bus(1'b1, `REG_WIN_START, 32'h100);
      bus(1'b1, `REG_WIN_END, 32'h101);
      ws = 12'h100;
      we = 12'h101;
      traffic(80);
      bus(1'b1, `REG_ERR_CNT, 32'h0);
      rdchk(`REG_ERR_CNT, 32'h0, "err_cnt");
      test_done();
   end
endmodule // region_decoder_bench
